// ### core/pin_config_pkg.sv
// Purpose: Constants for the socket B pin function and extended mode registers
// Assumes: Eight-bit index/data register port on the host I/O bus
// Notes: Index values are register indices, not byte addresses
`default_nettype none
package pin_config_pkg;
	localparam logic [9:0] INDEX_PORT_ADDR = 10'h3e0;
	localparam logic [9:0] DATA_PORT_ADDR = 10'h3e1;
	localparam logic [7:0] IDX_EXTENDED_MODE_A = 8'h3c;
	localparam logic [7:0] IDX_SOCKET_B_PIN_CONFIG = 8'h7b;
	localparam logic [7:0] IDX_EXTENDED_MODE_B = 8'h7c;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam logic [7:0] PIN_CONFIG_WRITE_MASK = 8'hf0;
	localparam logic [7:0] MODE_B_WRITE_MASK = 8'h01;
	// Field positions
	localparam int SEL_LSB = 4;
	localparam int SEL_MSB = 6;
	localparam int PNP_BIT = 0;
	localparam int IRQ7_ACK_BIT = 7;
	localparam int RING_TO_COMBINED_INTERRUPT_PIN_BIT = 6;
	localparam int LATER_STEP_BIT = 4;
	localparam int CABLE_DRIVE_BIT = 3;
	localparam int INTERNAL_SENSE_BIT = 2;
	localparam int STEER_LSB = 0;
	localparam int STEER_MSB = 1;
	localparam int THRESHOLD_BIT = 0;
	localparam int BUS_SIGNALS = 4;
	typedef enum logic [2:0] {
		FN_UNUSED0 = 3'b000,
		FN_RING = 3'b001,
		FN_UNUSED2 = 3'b010,
		FN_GENERAL = 3'b011,
		FN_SELECT = 3'b100,
		FN_LAMP = 3'b101,
		FN_UNUSED6 = 3'b110,
		FN_DMA_REQ = 3'b111
	} pin_function_t;
	typedef enum logic [1:0] {
		STEER_NONE = 2'b00,
		STEER_IRQ = 2'b01,
		STEER_SENSE2 = 2'b10,
		STEER_GPIO = 2'b11
	} prog_voltage_steer_t;
endpackage : pin_config_pkg
`default_nettype wire

// ### core/socket_pin_function_config.sv
// Purpose: Socket B pin function select, extended mode A and B registers
// Assumes: Host strobes are one-cycle pulses synchronous to sys_clk
// Notes: Pin outputs use out/oe pairs; the bench resolves the bus and socket B pin wires
// Behaviour
// - Select 1,3,4,5 drive socket B pin
// - Select 7 makes pin host DMA request
// - Pin config bits 0-3 ignore writes
// - Pin config bits 3:1 read zero
// - Bit 0 reports plug-and-play availability
// - Mode A bit 7 makes IRQ7 DMA acknowledge
// - Mode A bit 6 routes ring to interrupt
// - Mode A bit 4 selects later stepping
// - Mode A bit 3 makes bus outputs totem-pole
// - Mode A bit 2 selects internal voltage sense
// - Internal sense bit blocked in extended configuration
// - Mode A bits 1:0 steer programming-voltage enables
// - Mode B bit 0 sets socket B threshold in buffered configuration
// - External decode uses socket A chip select
`default_nettype none
module socket_pin_function_config (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [9:0] hostAddr,
	input wire logic [7:0] hostDataIn,
	input wire logic hostWrite,
	input wire logic hostRead,
	output logic [7:0] hostDataOut,
	output logic hostDataOe,
	input wire logic externalDecodeEnable,
	input wire logic chipSelectInN,
	input wire logic pnpAvailableStrap,
	input wire logic extendedConfig,
	input wire logic bufferedConfig,
	input wire logic ringIndicate,
	input wire logic generalOutput,
	input wire logic programmableSelect,
	input wire logic activityLamp,
	input wire logic hostDmaRequest,
	input wire logic interruptRequest,
	input wire logic irq7Request,
	input wire logic hostDmaAckInN,
	input wire logic progVoltageEnableA,
	input wire logic progVoltageEnableB,
	input wire logic [3:0] busAssert,
	output logic socketBPinOut,
	output logic socketBPinOe,
	output logic irq7Out,
	output logic irq7Oe,
	output logic hostDmaAck,
	output logic combinedInterruptPin,
	output logic [3:0] busPinOut,
	output logic [3:0] busPinOe,
	output logic laterStepCompat,
	output logic internalVoltageSense,
	output logic irq10Out,
	output logic irq11Out,
	output logic irqVppOe,
	output logic voltageSense2AOut,
	output logic voltageSense2BOut,
	output logic voltageSense2Oe,
	output logic progVoltageToGpioA,
	output logic socketBThreshold3v3
);
	typedef struct packed {
		logic [7:0] index;
		logic [7:0] modeA;
		logic [7:0] pinConfig;
		logic [7:0] modeB;
		logic pnpSeen;
		logic pnpAvailable;
		logic [7:0] dataOut;
		logic dataOe;
		logic pinOut;
		logic pinOe;
		logic irq7Out;
		logic irq7Oe;
		logic dmaAck;
		logic intrPin;
		logic [3:0] busOut;
		logic [3:0] busOe;
		logic laterStep;
		logic internalSense;
		logic irq10;
		logic irq11;
		logic irqVppOe;
		logic sense2A;
		logic sense2B;
		logic sense2Oe;
		logic vppGpioA;
		logic threshold;
	} state_t;

	state_t stateQ;
	state_t stateD;

	// Port selection shared by read and write paths
	function automatic logic portHit(
		input logic [9:0] addr,
		input logic [9:0] port,
		input logic external_decode_enable,
		input logic csN
	);
		if (external_decode_enable) begin
			portHit = !csN && (addr[0] == port[0]);
		end else begin
			portHit = (addr == port);
		end
	endfunction : portHit

	logic indexHit;
	logic dataHit;
	logic [7:0] readValue;
	pin_config_pkg::pin_function_t pinFunction;
	pin_config_pkg::prog_voltage_steer_t steer;

	assign indexHit = portHit(hostAddr, pin_config_pkg::INDEX_PORT_ADDR,
		externalDecodeEnable, chipSelectInN);
	assign dataHit = portHit(hostAddr, pin_config_pkg::DATA_PORT_ADDR,
		externalDecodeEnable, chipSelectInN);
	assign pinFunction = pin_config_pkg::pin_function_t'(
		stateQ.pinConfig[pin_config_pkg::SEL_MSB:pin_config_pkg::SEL_LSB]);
	assign steer = pin_config_pkg::prog_voltage_steer_t'(
		stateQ.modeA[pin_config_pkg::STEER_MSB:pin_config_pkg::STEER_LSB]);

	always_comb begin
		readValue = 8'h00;
		case (stateQ.index)
			pin_config_pkg::IDX_EXTENDED_MODE_A: begin
				readValue = stateQ.modeA;
			end
			pin_config_pkg::IDX_SOCKET_B_PIN_CONFIG: begin
				readValue = stateQ.pinConfig & pin_config_pkg::PIN_CONFIG_WRITE_MASK;
				readValue[pin_config_pkg::PNP_BIT] = stateQ.pnpAvailable;
			end
			pin_config_pkg::IDX_EXTENDED_MODE_B: begin
				readValue = stateQ.modeB & pin_config_pkg::MODE_B_WRITE_MASK;
			end
			default: begin
				readValue = 8'h00;
			end
		endcase
	end

	always_comb begin
		stateD = stateQ;
		// Strap is caught on the first edge after reset, never under reset
		if (!stateQ.pnpSeen) begin
			stateD.pnpSeen = 1'b1;
			stateD.pnpAvailable = pnpAvailableStrap;
		end
		if (hostWrite && indexHit) begin
			stateD.index = hostDataIn;
		end
		if (hostWrite && dataHit) begin
			case (stateQ.index)
				pin_config_pkg::IDX_EXTENDED_MODE_A: begin
					stateD.modeA = hostDataIn;
				end
				pin_config_pkg::IDX_SOCKET_B_PIN_CONFIG: begin
					stateD.pinConfig = hostDataIn & pin_config_pkg::PIN_CONFIG_WRITE_MASK;
				end
				pin_config_pkg::IDX_EXTENDED_MODE_B: begin
					stateD.modeB = hostDataIn & pin_config_pkg::MODE_B_WRITE_MASK;
				end
				default: begin
				end
			endcase
		end
		// Also clears a stale bit if extended configuration comes up later
		if (extendedConfig) begin
			stateD.modeA[pin_config_pkg::INTERNAL_SENSE_BIT] = 1'b0;
		end
		stateD.dataOut = (hostRead && dataHit) ? readValue : 8'h00;
		stateD.dataOe = hostRead && dataHit;

		// Socket B pin; unused codes and external decode leave it an input
		stateD.pinOut = 1'b1;
		stateD.pinOe = 1'b0;
		if (!externalDecodeEnable) begin
			case (pinFunction)
				pin_config_pkg::FN_RING: begin
					stateD.pinOut = !ringIndicate;
					stateD.pinOe = 1'b1;
				end
				pin_config_pkg::FN_GENERAL: begin
					stateD.pinOut = (steer == pin_config_pkg::STEER_GPIO) ? progVoltageEnableB
						: generalOutput;
					stateD.pinOe = 1'b1;
				end
				pin_config_pkg::FN_SELECT: begin
					stateD.pinOut = !programmableSelect;
					stateD.pinOe = 1'b1;
				end
				pin_config_pkg::FN_LAMP: begin
					stateD.pinOut = !activityLamp;
					stateD.pinOe = 1'b1;
				end
				pin_config_pkg::FN_DMA_REQ: begin
					stateD.pinOut = hostDmaRequest;
					stateD.pinOe = 1'b1;
				end
				default: begin
					stateD.pinOut = 1'b1;
					stateD.pinOe = 1'b0;
				end
			endcase
		end

		// IRQ7 turns into an input while acknowledge mode is set
		if (stateQ.modeA[pin_config_pkg::IRQ7_ACK_BIT]) begin
			stateD.irq7Out = 1'b0;
			stateD.irq7Oe = 1'b0;
			stateD.dmaAck = !hostDmaAckInN;
		end else begin
			stateD.irq7Out = irq7Request;
			stateD.irq7Oe = 1'b1;
			stateD.dmaAck = 1'b0;
		end

		stateD.intrPin = interruptRequest ||
			(stateQ.modeA[pin_config_pkg::RING_TO_COMBINED_INTERRUPT_PIN_BIT] && ringIndicate);

		for (int i = 0; i < pin_config_pkg::BUS_SIGNALS; i++) begin
			if (stateQ.modeA[pin_config_pkg::CABLE_DRIVE_BIT]) begin
				stateD.busOut[i] = !busAssert[i];
				stateD.busOe[i] = 1'b1;
			end else begin
				stateD.busOut[i] = 1'b0;
				stateD.busOe[i] = busAssert[i];
			end
		end

		stateD.laterStep = stateQ.modeA[pin_config_pkg::LATER_STEP_BIT];
		stateD.internalSense = stateQ.modeA[pin_config_pkg::INTERNAL_SENSE_BIT];

		stateD.irq10 = 1'b0;
		stateD.irq11 = 1'b0;
		stateD.irqVppOe = 1'b0;
		stateD.sense2A = 1'b1;
		stateD.sense2B = 1'b1;
		stateD.sense2Oe = 1'b0;
		stateD.vppGpioA = 1'b0;
		case (steer)
			pin_config_pkg::STEER_IRQ: begin
				stateD.irq10 = progVoltageEnableA;
				stateD.irq11 = progVoltageEnableB;
				stateD.irqVppOe = 1'b1;
			end
			pin_config_pkg::STEER_SENSE2: begin
				stateD.sense2A = progVoltageEnableA;
				stateD.sense2B = progVoltageEnableB;
				stateD.sense2Oe = 1'b1;
			end
			pin_config_pkg::STEER_GPIO: begin
				stateD.vppGpioA = 1'b1;
			end
			default: begin
			end
		endcase

		// Threshold only matters in the buffered configuration
		stateD.threshold = bufferedConfig &&
			stateQ.modeB[pin_config_pkg::THRESHOLD_BIT];
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			stateQ <= '0;
			stateQ.pinOut <= 1'b1;
			stateQ.sense2A <= 1'b1;
			stateQ.sense2B <= 1'b1;
		end else begin
			stateQ <= stateD;
		end
	end

	assign hostDataOut = stateQ.dataOut;
	assign hostDataOe = stateQ.dataOe;
	assign socketBPinOut = stateQ.pinOut;
	assign socketBPinOe = stateQ.pinOe;
	assign irq7Out = stateQ.irq7Out;
	assign irq7Oe = stateQ.irq7Oe;
	assign hostDmaAck = stateQ.dmaAck;
	assign combinedInterruptPin = stateQ.intrPin;
	assign busPinOut = stateQ.busOut;
	assign busPinOe = stateQ.busOe;
	assign laterStepCompat = stateQ.laterStep;
	assign internalVoltageSense = stateQ.internalSense;
	assign irq10Out = stateQ.irq10;
	assign irq11Out = stateQ.irq11;
	assign irqVppOe = stateQ.irqVppOe;
	assign voltageSense2AOut = stateQ.sense2A;
	assign voltageSense2BOut = stateQ.sense2B;
	assign voltageSense2Oe = stateQ.sense2Oe;
	assign progVoltageToGpioA = stateQ.vppGpioA;
	assign socketBThreshold3v3 = stateQ.threshold;

	a_dma_request_pin: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!externalDecodeEnable && pinFunction == pin_config_pkg::FN_DMA_REQ)
			|=> (socketBPinOe && socketBPinOut == $past(hostDmaRequest)))
		else $error("DMA request not on socket B pin");
	a_unused_select_input: assert property (@(posedge sys_clk) disable iff (!nrst)
		(externalDecodeEnable || pinFunction inside {pin_config_pkg::FN_UNUSED0,
			pin_config_pkg::FN_UNUSED2, pin_config_pkg::FN_UNUSED6}) |=> !socketBPinOe)
		else $error("Socket B pin driven while unused");
	a_low_bits_readonly: assert property (@(posedge sys_clk) disable iff (!nrst)
		stateQ.pinConfig[3:0] == 4'h0)
		else $error("Read-only pin config bits took a write");
	a_pin_config_read: assert property (@(posedge sys_clk) disable iff (!nrst)
		(hostRead && dataHit && stateQ.index == pin_config_pkg::IDX_SOCKET_B_PIN_CONFIG)
			|=> (hostDataOe && hostDataOut[3:1] == 3'b000
				&& hostDataOut[0] == stateQ.pnpAvailable))
		else $error("Pin config read returned reserved bits");
	a_irq7_ack_mode: assert property (@(posedge sys_clk) disable iff (!nrst)
		stateQ.modeA[pin_config_pkg::IRQ7_ACK_BIT] && !hostDmaAckInN
			|=> (!irq7Oe && hostDmaAck))
		else $error("IRQ7 acknowledge mode wrong");
	a_ring_to_combined_interrupt_pin: assert property (@(posedge sys_clk) disable iff (!nrst)
		(stateQ.modeA[pin_config_pkg::RING_TO_COMBINED_INTERRUPT_PIN_BIT] && ringIndicate)
			|=> combinedInterruptPin)
		else $error("Ring not routed to interrupt pin");
	a_cable_drive: assert property (@(posedge sys_clk) disable iff (!nrst)
		!stateQ.modeA[pin_config_pkg::CABLE_DRIVE_BIT] |=> (busPinOut == 4'h0))
		else $error("Open-drain bus pins drove high");
	a_sense_blocked: assert property (@(posedge sys_clk) disable iff (!nrst)
		extendedConfig |=> !stateQ.modeA[pin_config_pkg::INTERNAL_SENSE_BIT])
		else $error("Internal sense set in extended configuration");
	a_vpp_irq_steer: assert property (@(posedge sys_clk) disable iff (!nrst)
		(steer == pin_config_pkg::STEER_IRQ) |=> (irqVppOe
			&& irq10Out == $past(progVoltageEnableA)
			&& irq11Out == $past(progVoltageEnableB)))
		else $error("Programming voltage not steered to IRQ10/11");
	a_threshold_select: assert property (@(posedge sys_clk) disable iff (!nrst)
		!bufferedConfig |=> !socketBThreshold3v3)
		else $error("Threshold set outside buffered configuration");
endmodule : socket_pin_function_config
`default_nettype wire

// ### tb/socket_side_model.sv
// Purpose: Far-side wires of the host bus lines and the socket B pin
// Assumes: Pull-ups on every bus line and on the socket B pin, which the block may release
// Notes: A released line reads high, never the last driven value
`default_nettype none
module socket_side_model (
	input wire logic [3:0] busPinOut,
	input wire logic [3:0] busPinOe,
	input wire logic socketBPinOut,
	input wire logic socketBPinOe,
	output logic [3:0] busWire,
	output logic socketBPin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Shared bus lines, so undriven means pulled high
	always_comb begin
		for (int i = 0; i < 4; i++) busWire[i] = busPinOe[i] ? busPinOut[i] : 1'b1;
	end
	// Pin defaults to an input and needs the pull-up
	assign socketBPin = socketBPinOe ? socketBPinOut : 1'b1;
endmodule : socket_side_model
`default_nettype wire

// ### tb/socket_pin_function_config_tb.sv
// Purpose: Self-checking bench for the socket B pin function registers
// Assumes: Default port pair; chip select held low for external decode
// Notes: Inputs change on the falling edge only
`default_nettype none
module socket_pin_function_config_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] MA = pin_config_pkg::IDX_EXTENDED_MODE_A;
	localparam logic [7:0] PC = pin_config_pkg::IDX_SOCKET_B_PIN_CONFIG;
	localparam logic [7:0] MB = pin_config_pkg::IDX_EXTENDED_MODE_B;
	logic sys_clk = 0, nrst = 0, hostWrite = 0, hostRead = 0, hostDataOe;
	logic [9:0] hostAddr = 10'h000;
	logic [7:0] hostDataIn = 8'h00, hostDataOut;
	logic externalDecodeEnable = 0, chipSelectInN = 0, pnpAvailableStrap = 1;
	logic extendedConfig = 0, bufferedConfig = 1, ringIndicate = 0, generalOutput = 0;
	logic programmableSelect = 0, activityLamp = 0, hostDmaRequest = 0, interruptRequest = 0;
	logic irq7Request = 1, hostDmaAckInN = 1, progVoltageEnableA = 0, progVoltageEnableB = 0;
	logic [3:0] busAssert = 4'h5, busPinOut, busPinOe, busWire;
	logic socketBPinOut, socketBPinOe, irq7Out, irq7Oe, hostDmaAck, combinedInterruptPin;
	logic laterStepCompat, internalVoltageSense, irq10Out, irq11Out, irqVppOe, socketBPin;
	logic voltageSense2AOut, voltageSense2BOut, voltageSense2Oe, progVoltageToGpioA;
	logic socketBThreshold3v3;
	int errCount = 0, compares = 0;

	socket_pin_function_config uut (.sys_clk, .nrst, .hostAddr, .hostDataIn, .hostWrite,
		.hostRead, .hostDataOut, .hostDataOe, .externalDecodeEnable, .chipSelectInN,
		.pnpAvailableStrap, .extendedConfig, .bufferedConfig, .ringIndicate, .generalOutput,
		.programmableSelect, .activityLamp, .hostDmaRequest, .interruptRequest, .irq7Request,
		.hostDmaAckInN, .progVoltageEnableA, .progVoltageEnableB, .busAssert, .socketBPinOut,
		.socketBPinOe, .irq7Out, .irq7Oe, .hostDmaAck, .combinedInterruptPin, .busPinOut,
		.busPinOe, .laterStepCompat, .internalVoltageSense, .irq10Out, .irq11Out, .irqVppOe,
		.voltageSense2AOut, .voltageSense2BOut, .voltageSense2Oe, .progVoltageToGpioA,
		.socketBThreshold3v3);
	socket_side_model far (.busPinOut, .busPinOe, .socketBPinOut, .socketBPinOe, .busWire,
		.socketBPin);

	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic conclude;
		if (errCount == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude

	task automatic cb(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			errCount++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : cb

	task automatic c1(input string n, input logic e, input logic g);
		cb(n, {7'h00, e}, {7'h00, g});
	endtask : c1

	task automatic idxw(input logic [7:0] idx);
		@(negedge sys_clk);
		hostAddr = pin_config_pkg::INDEX_PORT_ADDR;
		hostDataIn = idx;
		hostWrite = 1;
		@(negedge sys_clk);
	endtask : idxw

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		idxw(idx);
		hostAddr = pin_config_pkg::DATA_PORT_ADDR;
		hostDataIn = v;
		@(negedge sys_clk);
		hostWrite = 0;
	endtask : wr

	task automatic rc(input string n, input logic [7:0] idx, input logic [7:0] e);
		logic got;
		idxw(idx);
		hostWrite = 0;
		hostAddr = pin_config_pkg::DATA_PORT_ADDR;
		hostRead = 1;
		got = 0;
		@(negedge sys_clk);
		hostRead = 0;
		for (int i = 0; i < 3 && !got; i++) begin
			if (hostDataOe === 1'b1) got = 1;
			else @(negedge sys_clk);
		end
		if (!got) begin
			errCount++;
			$display("BAD %s expected answer seen none", n);
			conclude();
		end else begin
			cb(n, e, hostDataOut);
		end
	endtask : rc

	// Pin outputs lag their inputs by one clock
	task automatic st;
		repeat (2) @(negedge sys_clk);
	endtask : st

	initial begin
		logic unused;
		logic ex;
		repeat (12) @(negedge sys_clk);
		nrst = 1;
		@(negedge sys_clk);
		rc("modeA", MA, 8'h00);
		rc("pinCfg", PC, 8'h01);
		rc("modeB", MB, 8'h00);
		rc("unmapped", 8'h10, 8'h00);
		c1("irq7Oe", 1'b1, irq7Oe);
		c1("irq7Out", 1'b1, irq7Out);
		cb("busOeOpen", 8'h05, {4'h0, busPinOe});
		cb("busWireOpen", 8'h0a, {4'h0, busWire});
		wr(PC, 8'hff);
		rc("pinCfgRo", PC, 8'hf1);
		for (int c = 0; c < 8; c++) begin
			wr(PC, {1'b0, c[2:0], 4'h0});
			for (int v = 0; v < 2; v++) begin
				ringIndicate = (c == 1) ? v[0] : !v[0];
				generalOutput = (c == 3) ? v[0] : !v[0];
				programmableSelect = (c == 4) ? v[0] : !v[0];
				activityLamp = (c == 5) ? v[0] : !v[0];
				hostDmaRequest = (c == 7) ? v[0] : !v[0];
				unused = (c == 0 || c == 2 || c == 6);
				ex = unused ? 1'b1 : ((c == 3 || c == 7) ? v[0] : !v[0]);
				st();
				c1("pinOe", !unused, socketBPinOe);
				c1("pin", ex, socketBPin);
			end
		end
		wr(PC, 8'h10);
		externalDecodeEnable = 1;
		st();
		c1("pinOeExt", 1'b0, socketBPinOe);
		rc("pinCfgExt", PC, 8'h11);
		externalDecodeEnable = 0;
		extendedConfig = 1;
		wr(MA, 8'hff);
		rc("modeAExt", MA, 8'hfb);
		extendedConfig = 0;
		wr(MA, 8'hff);
		rc("modeA", MA, 8'hff);
		hostDmaAckInN = 0;
		ringIndicate = 1;
		progVoltageEnableB = 1;
		wr(PC, 8'h30);
		st();
		c1("dmaAck", 1'b1, hostDmaAck);
		c1("irq7OeAck", 1'b0, irq7Oe);
		c1("combined_interrupt_pin", 1'b1, combinedInterruptPin);
		c1("laterStep", 1'b1, laterStepCompat);
		c1("intSense", 1'b1, internalVoltageSense);
		cb("busOeTotem", 8'h0f, {4'h0, busPinOe});
		cb("busWireTotem", 8'h0a, {4'h0, busWire});
		c1("pinVpp", 1'b1, socketBPin);
		c1("pinVppOe", 1'b1, socketBPinOe);
		for (int s = 0; s < 4; s++) begin
			wr(MA, {6'h00, s[1:0]});
			st();
			c1("vppIrqOe", s == 1, irqVppOe);
			c1("vs2Oe", s == 2, voltageSense2Oe);
			c1("vppGpio", s == 3, progVoltageToGpioA);
			if (s == 1) c1("irq11", 1'b1, irq11Out);
			if (s == 1) c1("irq10", 1'b0, irq10Out);
			if (s == 2) c1("vs2B", 1'b1, voltageSense2BOut);
			if (s == 2) c1("vs2A", 1'b0, voltageSense2AOut);
		end
		c1("intrOff", 1'b0, combinedInterruptPin);
		interruptRequest = 1;
		st();
		c1("intrReq", 1'b1, combinedInterruptPin);
		interruptRequest = 0;
		c1("irq7OeBack", 1'b1, irq7Oe);
		c1("earlyStep", 1'b0, laterStepCompat);
		wr(MB, 8'hff);
		rc("modeBRo", MB, 8'h01);
		st();
		c1("thr", 1'b1, socketBThreshold3v3);
		bufferedConfig = 0;
		st();
		c1("thrUnbuf", 1'b0, socketBThreshold3v3);
		nrst = 0;
		st();
		nrst = 1;
		@(negedge sys_clk);
		rc("modeBRst", MB, 8'h00);
		rc("pinCfgRst", PC, 8'h01);
		rc("modeARst", MA, 8'h00);
		conclude();
	end
endmodule : socket_pin_function_config_tb
`default_nettype wire
